// ---- core_event_model.sv ----
// core event unit model: latches rising edges of the seven gp inputs
// assumes gp_req_i comes from the router on the same clock
`timescale 1ns/1ps
module core_event_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [6:0] gp_req_i,
	output logic      [3:0] top_o
);
	logic [6:0] prev;
	logic [6:0] latched;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev    <= 7'h00;
			latched <= 7'h00;
		end else begin
			prev    <= gp_req_i;
			// a withdrawn request leaves no pending event
			latched <= (latched | (gp_req_i & ~prev)) & gp_req_i;
		end
	end
	// lowest input number wins, gp input 7 first
	always_comb begin
		top_o = 4'h0;
		for (int g = 6; g >= 0; g--) begin
			if (latched[g]) begin
				top_o = 4'(7 + g);
			end
		end
	end
endmodule // core_event_model

// ---- route_matrix.sv ----
// combinational steering of unmasked sources onto the core inputs
// assumes assignment fields already hold only legal core ids
`timescale 1ns/1ps
module route_matrix (
	input  wire logic [55:0]      src_i,
	input  wire logic [55:0]      mask_i,
	input  wire logic [55:0][3:0] assign_i,
	output logic      [6:0]       req_o
);

	logic [55:0] live;

	assign live = src_i & mask_i; // [RULE9]

	genvar g;
	genvar s;
	generate
		for (g = 0; g < router_pkg::NUM_GP; g++) begin : gp
			logic [55:0] pick;
			for (s = 0; s < router_pkg::NUM_SOURCES; s++) begin : src
				assign pick[s] = (assign_i[s] == 4'(g)); // [RULE1]
			end
			assign req_o[g] = |(live & pick); // [RULE12] [RULE6]
		end
	endgenerate

endmodule // route_matrix

// ---- router_pkg.sv ----
// constants, register map and reset values of the system interrupt router
// assumes a classic wishbone slave port with 32-bit data and byte addresses
package router_pkg;

	localparam int NUM_SOURCES = 56;
	localparam int NUM_GP      = 7;
	localparam int FIELD_W     = 4;
	localparam int PER_ASSIGN  = 8;
	localparam int NUM_ASSIGN  = 7;
	localparam int BANK_W      = 32;
	localparam int BANK1_BYTES = 3;
	localparam int BANK0_BYTES = 4;
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 32;

	// core event ordering, 0 is highest
	localparam int PRIO_EMULATION = 0;
	localparam int PRIO_RESET     = 1;
	localparam int PRIO_NMI       = 2;
	localparam int PRIO_EXCEPTION = 3;
	localparam int PRIO_RESERVED  = 4;
	localparam int PRIO_HW_ERROR  = 5;
	localparam int PRIO_CORE_TMR  = 6;
	localparam int PRIO_GP_FIRST  = 7;
	localparam int PRIO_GP_LAST   = 15;

	// core interrupt id = gp input number minus seven
	localparam logic [3:0] MAX_CORE_ID = 4'h6;

	// word offsets, byte addresses
	localparam logic [7:0] MASK0_ADDR   = 8'h00;
	localparam logic [7:0] MASK1_ADDR   = 8'h04;
	localparam logic [7:0] STATUS0_ADDR = 8'h08;
	localparam logic [7:0] STATUS1_ADDR = 8'h0C;
	localparam logic [7:0] WAKE0_ADDR   = 8'h10;
	localparam logic [7:0] WAKE1_ADDR   = 8'h14;
	localparam logic [7:0] ASSIGN_BASE  = 8'h20;
	localparam logic [7:0] ASSIGN_LAST  = 8'h38;

	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] WAKE_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

	// default mapping, register 6 down to register 0
	localparam logic [55:0][3:0] ASSIGN_RESET = {
		32'h3333_3000,
		32'h0666_6655,
		32'h5555_5555,
		32'h4444_4433,
		32'h3333_2222,
		32'h1100_0000,
		32'h0000_0000
	};

endpackage

// ---- system_router.sv ----
// system interrupt router: 56 sources onto seven core general-purpose inputs
// assumes sources and bus master run on clk_i; requests are levels
//
// Function
// (RULE1) each source drives exactly one core input
// (RULE2) software rewrites assignment, new mapping used next
// (RULE3) assignment fields reset to default mapping
// (RULE4) core ordering: fixed events, then inputs 7-15
// (RULE5) field value is input number minus seven
// (RULE6) several sources may share one core input
// (RULE7) eight assignment fields per register, seven registers
// (RULE8) bank0 holds ids 0-31, bank1 32-55
// (RULE9) set mask bit passes source, clear blocks
// (RULE10) status bit reads live source request
// (RULE11) wake-enabled source assertion wakes the core
// (RULE12) core request is OR of selecting unmasked sources
`timescale 1ns/1ps
module system_router (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic [55:0] src_i,
	output logic      [6:0]  gp_req_o,
	output logic             wake_o
);

	typedef struct packed {
		logic [55:0]      mask;
		logic [55:0]      wake;
		logic [55:0][3:0] assign_f;
		logic             ack;
		logic [31:0]      rdata;
		logic [6:0]       gp_req;
		logic             wake_out;
	} state_t;

	state_t      st;
	state_t      next_st;
	logic [6:0]  routed;
	logic        take;
	logic        in_assign;
	logic [2:0]  assign_idx;
	logic [7:0]  assign_off;

	route_matrix matrix (
		.src_i    (src_i),
		.mask_i   (st.mask),
		.assign_i (st.assign_f),
		.req_o    (routed)
	);

	assign take       = cyc_i && stb_i && !st.ack;
	assign in_assign  = (adr_i >= router_pkg::ASSIGN_BASE) &&
	                    (adr_i <= router_pkg::ASSIGN_LAST) && (adr_i[1:0] == 2'b00);
	assign assign_off = adr_i - router_pkg::ASSIGN_BASE;
	assign assign_idx = assign_off[4:2]; // [RULE7]

	always_comb begin
		next_st          = st;
		next_st.ack      = 1'b0;
		next_st.gp_req   = routed;
		next_st.wake_out = |(src_i & st.wake); // [RULE11]
		if (take) begin
			next_st.ack   = 1'b1;
			next_st.rdata = router_pkg::ZERO_WORD;
			if (adr_i == router_pkg::MASK0_ADDR) begin // [RULE8]
				next_st.rdata = st.mask[31:0];
				if (we_i) begin
					for (int b = 0; b < router_pkg::BANK0_BYTES; b++) begin
						if (sel_i[b]) begin
							next_st.mask[8*b +: 8] = dat_i[8*b +: 8];
						end
					end
				end
			end else if (adr_i == router_pkg::MASK1_ADDR) begin // [RULE8]
				next_st.rdata = {8'h00, st.mask[55:32]};
				if (we_i) begin
					for (int b = 0; b < router_pkg::BANK1_BYTES; b++) begin
						if (sel_i[b]) begin
							next_st.mask[router_pkg::BANK_W + 8*b +: 8] = dat_i[8*b +: 8];
						end
					end
				end
			end else if (adr_i == router_pkg::STATUS0_ADDR) begin
				next_st.rdata = src_i[31:0]; // [RULE10]
			end else if (adr_i == router_pkg::STATUS1_ADDR) begin
				next_st.rdata = {8'h00, src_i[55:32]}; // [RULE10]
			end else if (adr_i == router_pkg::WAKE0_ADDR) begin
				next_st.rdata = st.wake[31:0];
				if (we_i) begin
					for (int b = 0; b < router_pkg::BANK0_BYTES; b++) begin
						if (sel_i[b]) begin
							next_st.wake[8*b +: 8] = dat_i[8*b +: 8];
						end
					end
				end
			end else if (adr_i == router_pkg::WAKE1_ADDR) begin
				next_st.rdata = {8'h00, st.wake[55:32]};
				if (we_i) begin
					for (int b = 0; b < router_pkg::BANK1_BYTES; b++) begin
						if (sel_i[b]) begin
							next_st.wake[router_pkg::BANK_W + 8*b +: 8] = dat_i[8*b +: 8];
						end
					end
				end
			end else if (in_assign) begin
				next_st.rdata = st.assign_f[assign_idx*8 +: 8]; // [RULE7]
				if (we_i) begin
					for (int f = 0; f < router_pkg::PER_ASSIGN; f++) begin
						// illegal ids are dropped so every source keeps one target
						if (sel_i[f/2] && (dat_i[4*f +: 4] <= router_pkg::MAX_CORE_ID)) begin // [RULE5]
							next_st.assign_f[assign_idx*8 + f] = dat_i[4*f +: 4]; // [RULE2]
						end
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st          <= '0;
			st.mask     <= {router_pkg::MASK_RESET[23:0], router_pkg::MASK_RESET};
			st.wake     <= {router_pkg::WAKE_RESET[23:0], router_pkg::WAKE_RESET};
			st.assign_f <= router_pkg::ASSIGN_RESET; // [RULE3]
		end else begin
			st <= next_st;
		end
	end

	// output index g is core input 7+g, so index 0 has top priority
	assign gp_req_o = st.gp_req; // [RULE4]
	assign wake_o   = st.wake_out;
	assign dat_o    = st.rdata;
	assign ack_o    = st.ack;

	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o)
		else $error("request not answered in one cycle");

	reset_default_a: assert property (@(posedge clk_i) // [RULE3]
		($past(rst_i) && !rst_i) |-> (st.assign_f == router_pkg::ASSIGN_RESET && st.mask == '0))
		else $error("assignment not at default after reset");

	source_route_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
		(src_i[40] && st.mask[40] && !take)[*2] |-> gp_req_o[st.assign_f[40][2:0]])
		else $error("unmasked source did not reach its core input");

	mask_block_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
		((src_i & st.mask) == '0) |=> (gp_req_o == '0))
		else $error("core input raised with every source masked");

	status_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
		(take && !we_i && adr_i == router_pkg::STATUS1_ADDR) |=>
		(dat_o == {8'h00, $past(src_i[55:32])}))
		else $error("status read does not show live requests");

	wake_event_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
		((src_i & st.wake) != '0) |=> wake_o)
		else $error("wake-enabled source did not wake the core");

	assign_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
		(take && we_i && adr_i == router_pkg::ASSIGN_LAST && sel_i[3] &&
		 dat_i[31:28] <= router_pkg::MAX_CORE_ID) |=> (st.assign_f[55] == $past(dat_i[31:28])))
		else $error("assignment write not stored");

	assign_illegal_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
		(take && we_i && adr_i == router_pkg::ASSIGN_BASE &&
		 dat_i[3:0] > router_pkg::MAX_CORE_ID) |=> $stable(st.assign_f[0]))
		else $error("illegal core id accepted");

	legal_field_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
		st.assign_f[13] <= router_pkg::MAX_CORE_ID)
		else $error("source lost its core input");

	unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && adr_i == 8'hFC) |=> (dat_o == router_pkg::ZERO_WORD))
		else $error("unmapped address read nonzero");

	// per-source routing and field legality
	genvar s;
	generate
		for (s = 0; s < router_pkg::NUM_SOURCES; s++) begin : chk_src
			src_route_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
				(src_i[s] && st.mask[s]) |=> gp_req_o[$past(st.assign_f[s][2:0])])
				else $error("unmasked source missing on its core input");

			field_legal_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
				st.assign_f[s] <= router_pkg::MAX_CORE_ID)
				else $error("assignment field holds an illegal id");
		end
	endgenerate

	// register writes
	mask0_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		(take && we_i && adr_i == router_pkg::MASK0_ADDR && sel_i == 4'hF) |=>
		(st.mask[31:0] == $past(dat_i)))
		else $error("mask bank0 write not stored");

	mask1_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		(take && we_i && adr_i == router_pkg::MASK1_ADDR && sel_i == 4'hF) |=>
		(st.mask[55:32] == $past(dat_i[23:0])))
		else $error("mask bank1 write not stored");

	wake0_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
		(take && we_i && adr_i == router_pkg::WAKE0_ADDR && sel_i == 4'hF) |=>
		(st.wake[31:0] == $past(dat_i)))
		else $error("wake bank0 write not stored");

	wake1_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
		(take && we_i && adr_i == router_pkg::WAKE1_ADDR && sel_i == 4'hF) |=>
		(st.wake[55:32] == $past(dat_i[23:0])))
		else $error("wake bank1 write not stored");

	// register reads
	mask0_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		(take && !we_i && adr_i == router_pkg::MASK0_ADDR) |=>
		(dat_o == $past(st.mask[31:0])))
		else $error("mask bank0 read wrong");

	mask1_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		(take && !we_i && adr_i == router_pkg::MASK1_ADDR) |=>
		(dat_o == {8'h00, $past(st.mask[55:32])}))
		else $error("mask bank1 read wrong");

	wake0_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
		(take && !we_i && adr_i == router_pkg::WAKE0_ADDR) |=>
		(dat_o == $past(st.wake[31:0])))
		else $error("wake bank0 read wrong");

	wake1_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
		(take && !we_i && adr_i == router_pkg::WAKE1_ADDR) |=>
		(dat_o == {8'h00, $past(st.wake[55:32])}))
		else $error("wake bank1 read wrong");

	status0_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
		(take && !we_i && adr_i == router_pkg::STATUS0_ADDR) |=>
		(dat_o == $past(src_i[31:0])))
		else $error("status bank0 read wrong");

	assign_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
		(take && !we_i && in_assign) |=>
		(dat_o == $past(st.assign_f[assign_idx*8 +: 8])))
		else $error("assignment register read wrong");

	// quiet behaviour between accesses
	rdata_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!take |=> $stable(dat_o))
		else $error("read data changed without an access");

	config_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
		!take |=> ($stable(st.mask) && $stable(st.wake) && $stable(st.assign_f)))
		else $error("configuration changed without a write");

	ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without a request");

	wake_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
		((src_i & st.wake) == '0) |=> !wake_o)
		else $error("wake raised with no enabled source");

	reset_outputs_a: assert property (@(posedge clk_i)
		($past(rst_i) && !rst_i) |->
		(!ack_o && dat_o == router_pkg::ZERO_WORD && gp_req_o == '0 && !wake_o))
		else $error("outputs not quiet after reset");

endmodule // system_router

// ---- system_router_tb_top.sv ----
// testbench of the system interrupt router
// assumes classic wishbone master tasks and the core event model
`timescale 1ns/1ps
module system_router_tb_top;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc = 0, stb = 0, we = 0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] dat_o, q;
	logic        ack_o, wake_o;
	logic [55:0] src_i = '0;
	logic [6:0]  gp_req_o;
	logic [3:0]  top;
	int          n_mismatch = 0, samples_checked = 0, cycles = 0;
	logic [31:0] dflt [7] = '{32'h0000_0000, 32'h1100_0000, 32'h3333_2222,
		32'h4444_4433, 32'h5555_5555, 32'h0666_6655, 32'h3333_3000};

	system_router system_router_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.src_i(src_i), .gp_req_o(gp_req_o), .wake_o(wake_o));
	core_event_model core_event_model_i (.clk_i(clk_i), .rst_i(rst_i),
		.gp_req_i(gp_req_o), .top_o(top));

	always #10 clk_i = ~clk_i;

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 0; stb <= 0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	initial begin
		tick(10);
		rst_i <= 0;
		for (int r = 0; r < 7; r++) begin
			wb(0, router_pkg::ASSIGN_BASE + 8'(4 * r), 0);
			chk("assign", q, dflt[r]);
		end
		wb(0, router_pkg::MASK0_ADDR, 0);
		chk("mask0", q, 32'h0000_0000);
		src_i <= '1;
		tick(3);
		chk("gp", {25'h0, gp_req_o}, 32'h0000_0000);
		wb(1, router_pkg::MASK0_ADDR, 32'h0000_0020);
		tick(3);
		chk("gp", {25'h0, gp_req_o}, 32'h0000_0001);
		wb(1, router_pkg::MASK0_ADDR, 0);
		wb(1, router_pkg::MASK1_ADDR, 32'h0000_0100);
		src_i <= 56'h1 << 40;
		for (int g = 6; g >= 0; g--) begin
			wb(1, 8'h34, {dflt[5][31:4], 4'(g)});
			tick(3);
			chk("gp", {25'h0, gp_req_o}, 32'h1 << g);
			chk("top", {28'h0, top}, 32'(7 + g));
		end
		wb(1, 8'h34, {dflt[5][31:4], 4'h7});
		wb(0, 8'h34, 0);
		chk("assign5", q, {dflt[5][31:4], 4'h0});
		chk("gp", {25'h0, gp_req_o}, 32'h0000_0001);
		wb(1, router_pkg::MASK1_ADDR, 0);
		tick(3);
		chk("gp", {25'h0, gp_req_o}, 32'h0000_0000);
		chk("wake", {31'h0, wake_o}, 32'h0000_0000);
		wb(1, router_pkg::WAKE1_ADDR, 32'h0000_0100);
		tick(3);
		chk("wake", {31'h0, wake_o}, 32'h0000_0001);
		src_i <= 56'hAB_CDEF_1234_5678;
		tick(2);
		wb(0, router_pkg::STATUS0_ADDR, 0);
		chk("status0", q, 32'h1234_5678);
		wb(0, router_pkg::STATUS1_ADDR, 0);
		chk("status1", q, 32'h00AB_CDEF);
		wb(0, 8'hFC, 0);
		chk("unmapped", q, 32'h0000_0000);
		final_report();
	end
endmodule // system_router_tb_top
